// >>> verilog/uhcrm_pkg.sv
package uhcrm_pkg;
    // bus geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam logic [16:0] SPACE_LAST = 17'h003FF;
    // region bases
    localparam logic [16:0] OPER_BASE = 17'h00000;
    localparam logic [16:0] OPER_LAST = 17'h001FF;
    localparam logic [16:0] PERI_BASE = 17'h00200;
    localparam logic [16:0] PERI_LAST = 17'h002FF;
    localparam logic [16:0] CONF_BASE = 17'h00300;
    localparam logic [16:0] CONF_LAST = 17'h003FF;
    // capability registers
    localparam logic [16:0] CAP_LEN_OFS = 17'h00000;
    localparam logic [16:0] IF_VER_OFS = 17'h00002;
    localparam logic [16:0] STRUCT_OFS = 17'h00004;
    localparam logic [16:0] CAPPAR_OFS = 17'h00008;
    localparam logic [7:0] CAP_LEN_VAL = 8'h20;
    localparam logic [15:0] IF_VER_VAL = 16'h0100;
    // structural parameter fields
    localparam int PORTS_LSB = 0;
    localparam int PORT_POWER_BIT = 4;
    localparam int ROUTE_BIT = 7;
    localparam int PPCC_LSB = 8;
    localparam int CCOUNT_LSB = 12;
    localparam int INDIC_BIT = 16;
    localparam int DEBUG_LSB = 20;
    localparam logic [3:0] PORTS_VAL = 4'h1;
    localparam logic [3:0] DEBUG_VAL = 4'h0;
    localparam logic [31:0] CAPPAR_VAL = 32'h00000086;
    // capability parameter fields
    localparam int FRAME_FLAG_BIT = 1;
    localparam int PARK_BIT = 2;
    localparam int ISO_THRESH_LSB = 4;
    localparam int EXT_CAP_LSB = 8;
    localparam logic FRAME_FLAG_VAL = 1'h1;
    localparam logic PARK_VAL = 1'h1;
    localparam logic [3:0] ISO_THRESH_VAL = 4'h8;
    localparam logic [7:0] EXT_CAP_VAL = 8'h00;
    // register cell table, writable and read-only entries
    localparam int NREG = 34;
    localparam logic [16:0] REG_OFS [NREG] = '{
        17'h00020, 17'h00024, 17'h00028, 17'h0002C, 17'h00060, 17'h00064,
        17'h00130, 17'h00134, 17'h00138, 17'h00140, 17'h00144, 17'h00148,
        17'h00150, 17'h00154, 17'h00158, 17'h00300, 17'h00308, 17'h0030C,
        17'h00310, 17'h00314, 17'h00318, 17'h0031C, 17'h00320, 17'h00324,
        17'h00328, 17'h0032C, 17'h00330, 17'h00334, 17'h00338, 17'h0033C,
        17'h00340, 17'h00344, 17'h00354, 17'h00304};
    localparam logic [31:0] REG_RST [NREG] = '{
        32'h00080B00, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00002000, 32'h00000000, 32'hFFFFFFFF, 32'h00000000, 32'h00000000,
        32'hFFFFFFFF, 32'h00000000, 32'h00000000, 32'hFFFFFFFF, 32'h00000000,
        32'h00000100, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h0000000F, 32'h00000000, 32'h03E81BA0, 32'h00000000};
    // read-only entries: done maps and identifier
    localparam logic [NREG-1:0] REG_RO = 34'h200001240;
    localparam int CHIP_ID_IDX = 33;
    // table entries mirrored on outputs
    localparam int CMD_IDX = 0;
    localparam int PWRDN_IDX = 32;
    // controller command register fields
    localparam logic [3:0] CMD_OFS = 4'h0;
    localparam logic [3:0] CMD_DATA = 4'h4;
    localparam logic [3:0] CMD_CTRL = 4'h8;
    localparam logic [3:0] CMD_STAT = 4'hC;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WR = 1;
endpackage : uhcrm_pkg

// >>> verilog/uhcrm_if.sv
`timescale 1ns/100ps
`default_nettype none
interface uhcrm_if;
    logic [16:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wrStrobe;
    logic rdStrobe;
    logic rdValid;
    modport device (input addr, input wdata, input wrStrobe, input rdStrobe,
        output rdata, output rdValid);
    modport host (output addr, output wdata, output wrStrobe, output rdStrobe,
        input rdata, input rdValid);
endinterface : uhcrm_if
`default_nettype wire

// >>> verilog/uhcrm_word_reg.sv
`timescale 1ns/100ps
`default_nettype none
// one 32-bit register cell with reset value and write protection
module uhcrm_word_reg #(
    parameter logic [31:0] RST = 32'h00000000,
    parameter bit RO = 1'b0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wrEn,
    input wire logic [31:0] wdata,
    output logic [31:0] value
);
    // reset value, then full-word writes unless read-only
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            value <= RST;
        end else if (wrEn && !RO) begin
            value <= wdata;
        end
    end
endmodule : uhcrm_word_reg
`default_nettype wire

// >>> verilog/uhcrm_device.sv
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - decode 0000h-03FFh, whole 32-bit words only
// - operational, peripheral, configuration address regions
// - seventeen address lines on the bus
// - no byte access; address bits one and zero ignored
// - capability length reads constant 20h
// - interface version reads constant 0100h
// - structural parameters: one downstream port
// - port power control bit reads one
// - debug port index field reads zero
// - companion count and ports-per-companion zero
// - routing method and indicator bits zero
// - reserved structural bits read zero
// - skip maps reset ones, done/last zero
// - command, port, power-down reset values
// - capability parameters register at 0008h
module uhcrm_device
    import uhcrm_pkg::*;
#(
    parameter logic [31:0] CHIP_ID = 32'h0000A5A5 // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic resetn,
    uhcrm_if.device bus,
    output logic [31:0] hostCommand,
    output logic [31:0] powerDownControl,
    output logic [1:0] lastRegion
);
    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic [16:0] wordAddr;
    logic inSpace;
    logic inOper;
    logic inPeri;
    logic inConf;
    logic wrOk;
    logic [1:0] regionNow;
    // register cells and their read chain
    logic [31:0] regVal [NREG];
    logic [NREG-1:0] hit;
    logic [31:0] tableRd [NREG + 1];
    // capability words and read multiplexer
    logic [31:0] structuralParameters;
    logic [31:0] capabilityParameters;
    logic [31:0] capWord0;
    logic [31:0] capRd;
    logic [31:0] rdMux;

    // word-aligned address: low two bits never select bytes
    assign wordAddr = {bus.addr[16:2], 2'b00};
    assign inSpace = (bus.addr <= SPACE_LAST);

    // region flags for the current address
    assign inOper = (bus.addr <= OPER_LAST);
    assign inPeri = (bus.addr >= PERI_BASE) && (bus.addr <= PERI_LAST);
    assign inConf = (bus.addr >= CONF_BASE) && (bus.addr <= CONF_LAST);

    // writes land only in operational and configuration space
    assign wrOk = bus.wrStrobe && (inOper || inConf);

    // region code: 0 operational, 1 peripheral, 2 configuration, 3 outside
    always_comb begin
        regionNow = 2'h3;
        if (inOper) begin
            regionNow = 2'h0;
        end else if (inPeri) begin
            regionNow = 2'h1;
        end else if (inConf) begin
            regionNow = 2'h2;
        end
    end

    // structural parameters built field by field, reserved bits zero
    always_comb begin
        structuralParameters = 32'h00000000;
        structuralParameters[PORTS_LSB +: 4] = PORTS_VAL;
        structuralParameters[PORT_POWER_BIT] = 1'b1;
        structuralParameters[ROUTE_BIT] = 1'b0;
        structuralParameters[PPCC_LSB +: 4] = 4'h0;
        structuralParameters[CCOUNT_LSB +: 4] = 4'h0;
        structuralParameters[INDIC_BIT] = 1'b0;
        structuralParameters[DEBUG_LSB +: 4] = DEBUG_VAL;
    end
    // word 0 packs capability length low and interface version high
    assign capWord0 = {IF_VER_VAL, 8'h00, CAP_LEN_VAL};

    // capability parameters built field by field, reserved bits zero
    always_comb begin
        capabilityParameters = 32'h00000000;
        capabilityParameters[FRAME_FLAG_BIT] = FRAME_FLAG_VAL;
        capabilityParameters[PARK_BIT] = PARK_VAL;
        capabilityParameters[ISO_THRESH_LSB +: 4] = ISO_THRESH_VAL;
        capabilityParameters[EXT_CAP_LSB +: 8] = EXT_CAP_VAL;
    end

    // capability block: three constant words, anything else reads zero
    always_comb begin
        capRd = 32'h00000000;
        case (wordAddr)
            CAP_LEN_OFS: begin
                capRd = capWord0;
            end
            STRUCT_OFS: begin
                capRd = structuralParameters;
            end
            CAPPAR_OFS: begin
                capRd = capabilityParameters;
            end
            default: begin
                capRd = 32'h00000000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register cells, one per table entry
    assign tableRd[0] = 32'h00000000;
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : gReg
            assign hit[gi] = inSpace && (wordAddr == REG_OFS[gi]);
            assign tableRd[gi + 1] = tableRd[gi] | (hit[gi] ? regVal[gi] : 32'h00000000);
            uhcrm_word_reg #(
                .RST(gi == CHIP_ID_IDX ? CHIP_ID : REG_RST[gi]),
                .RO(REG_RO[gi])
            ) uReg (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .wrEn(wrOk && hit[gi]),
                .wdata(bus.wdata),
                .value(regVal[gi])
            );
        end
    endgenerate

    // read multiplexer; holes, peripheral space and outside addresses give zero
    always_comb begin
        rdMux = 32'h00000000;
        if (inSpace) begin
            rdMux = capRd | tableRd[NREG];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer flag one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bus.rdValid <= 1'b0;
        end else begin
            bus.rdValid <= bus.rdStrobe;
        end
    end

    // read data stand one cycle, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bus.rdata <= 32'h00000000;
        end else begin
            bus.rdata <= bus.rdStrobe ? rdMux : 32'h00000000;
        end
    end

    // region of the last access
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lastRegion <= 2'h0;
        end else if (bus.rdStrobe || bus.wrStrobe) begin
            lastRegion <= regionNow;
        end
    end

    // mirror of the command register, one cycle behind the cell
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hostCommand <= REG_RST[CMD_IDX];
        end else begin
            hostCommand <= regVal[CMD_IDX];
        end
    end

    // mirror of the power-down control register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            powerDownControl <= REG_RST[PWRDN_IDX];
        end else begin
            powerDownControl <= regVal[PWRDN_IDX];
        end
    end
endmodule : uhcrm_device
`default_nettype wire

// >>> verilog/uhcrm_host.sv
`timescale 1ns/100ps
`default_nettype none
// processor-side master: software gives offset, data and a go command
module uhcrm_host
    import uhcrm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] swAddr,
    input wire logic [31:0] swWdata,
    input wire logic swWr,
    input wire logic swRd,
    output logic [31:0] swRdata,
    uhcrm_if.host bus
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_WAIT = 3'b010,
        S_DONE = 3'b100
    } uhcrm_state_t;
    uhcrm_state_t state_r;
    logic [16:0] offset_r;
    logic [31:0] data_r;
    logic [31:0] result_r;
    logic busy_r;
    logic goWrite;
    logic goRead;

    assign goWrite = swWr && swAddr == CMD_CTRL && swWdata[CTRL_GO] && swWdata[CTRL_WR];
    assign goRead = swWr && swAddr == CMD_CTRL && swWdata[CTRL_GO] && !swWdata[CTRL_WR];

    // command registers; offset kept word aligned and within 17 bits
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            offset_r <= 17'h00000;
            data_r <= 32'h00000000;
        end else if (swWr && swAddr == CMD_OFS) begin
            offset_r <= {swWdata[16:2], 2'b00};
        end else if (swWr && swAddr == CMD_DATA) begin
            data_r <= swWdata;
        end
    end

    // one-cycle strobes and read capture
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            bus.addr <= 17'h00000;
            bus.wdata <= 32'h00000000;
            bus.wrStrobe <= 1'b0;
            bus.rdStrobe <= 1'b0;
            busy_r <= 1'b0;
            result_r <= 32'h00000000;
        end else begin
            bus.wrStrobe <= 1'b0;
            bus.rdStrobe <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (goWrite || goRead) begin
                        bus.addr <= offset_r;
                        bus.wdata <= data_r;
                        bus.wrStrobe <= goWrite;
                        bus.rdStrobe <= goRead;
                        busy_r <= 1'b1;
                        state_r <= goRead ? S_WAIT : S_DONE;
                    end
                end
                S_WAIT: begin
                    state_r <= S_DONE;
                end
                S_DONE: begin
                    if (bus.rdValid) begin
                        result_r <= bus.rdata;
                    end
                    busy_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // software read port, data one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            swRdata <= 32'h00000000;
        end else if (swRd) begin
            case (swAddr)
                CMD_OFS: swRdata <= {15'h0000, offset_r};
                CMD_DATA: swRdata <= result_r;
                CMD_STAT: swRdata <= {31'h00000000, busy_r};
                default: swRdata <= 32'h00000000;
            endcase
        end else begin
            swRdata <= 32'h00000000;
        end
    end
endmodule : uhcrm_host
`default_nettype wire

// >>> verification/uhcrm_sva.sv
`timescale 1ns/100ps
`default_nettype none
// watches the bus between host and device
module uhcrm_sva
    import uhcrm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [16:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic rdValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // read of one capability word
    sequence s_rd(logic [14:0] w);
        rdStrobe && addr[16:2] == w;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (rdStrobe |=> rdValid)
        else $error("read without answer");
    a_no_stray: assert property (!rdStrobe |=> !rdValid && rdata == 32'h0)
        else $error("stray read data");
    a_one_strobe: assert property (!(wrStrobe && rdStrobe))
        else $error("both strobes high");
    a_cap_word: assert property (s_rd(15'h0) |=>
        rdata == {IF_VER_VAL, 8'h00, CAP_LEN_VAL})
        else $error("capability word wrong");
    a_struct_ports: assert property (s_rd(15'h1) |=>
        rdata[3:0] == PORTS_VAL && rdata[4])
        else $error("port count or power bit wrong");
    a_struct_zero: assert property (s_rd(15'h1) |=>
        rdata[31:5] == 27'h0)
        else $error("structural zero fields set");
    a_cappar_word: assert property (s_rd(15'h2) |=> rdata == CAPPAR_VAL)
        else $error("capability parameters wrong");
    a_hole_zero: assert property (
        rdStrobe && addr > 17'h0000B && addr < 17'h00020 |=> rdata == 32'h0)
        else $error("hole reads nonzero");
    a_outside_zero: assert property (rdStrobe && addr > SPACE_LAST |=> rdata == 32'h0)
        else $error("outside space reads nonzero");
    a_reset_quiet: assert property ($rose(resetn) |-> !rdValid ##1 !rdValid)
        else $error("answer right after reset");
endmodule : uhcrm_sva
`default_nettype wire

// >>> verification/test_usb_host_capability_register_map.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_usb_host_capability_register_map
    import uhcrm_pkg::*;
;
    typedef struct {
        logic [16:0] ofs;
        logic [31:0] rst;
        logic [31:0] wd;
        logic [31:0] aft;
        logic [1:0] rgn;
    } uhcrm_row_t;
    localparam logic [31:0] ID = 32'h00005A5A; // arbitrary value
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic [3:0] swAddr = 4'h0;
    logic [31:0] swWdata = 32'h0;
    logic swWr = 1'h0;
    logic swRd = 1'h0;
    logic [31:0] swRdata, hostCommand, powerDownControl, d;
    logic [1:0] lastRegion;
    int errors = 0;
    int n_compared = 0;
    // offset, value read before the write, value written, value read back, region
    uhcrm_row_t rows [17] = '{
        '{17'h00000, 32'h01000020, 32'hFFFFFFFF, 32'h01000020, 2'h0},
        '{17'h00004, 32'h00000011, 32'hFFFFFFFF, 32'h00000011, 2'h0},
        '{17'h00008, 32'h00000086, 32'h00000000, 32'h00000086, 2'h0},
        '{17'h0000C, 32'h00000000, 32'hFFFFFFFF, 32'h00000000, 2'h0},
        '{17'h00020, 32'h00080B00, 32'h00080B01, 32'h00080B01, 2'h0},
        '{17'h00021, 32'h00080B01, 32'h00080B00, 32'h00080B00, 2'h0},
        '{17'h00064, 32'h00002000, 32'h0000A55A, 32'h0000A55A, 2'h0},
        '{17'h00130, 32'h00000000, 32'hFFFFFFFF, 32'h00000000, 2'h0},
        '{17'h00134, 32'hFFFFFFFF, 32'h00000000, 32'h00000000, 2'h0},
        '{17'h00144, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0000FFFF, 2'h0},
        '{17'h00154, 32'hFFFFFFFF, 32'h00000000, 32'h00000000, 2'h0},
        '{17'h00158, 32'h00000000, 32'h0000001F, 32'h0000001F, 2'h0},
        '{17'h00200, 32'h00000000, 32'hFFFFFFFF, 32'h00000000, 2'h1},
        '{17'h00304, ID, 32'h00000000, ID, 2'h2},
        '{17'h00340, 32'h0000000F, 32'h00000000, 32'h00000000, 2'h2},
        '{17'h00354, 32'h03E81BA0, 32'h00000000, 32'h00000000, 2'h2},
        '{17'h00400, 32'h00000000, 32'hFFFFFFFF, 32'h00000000, 2'h3}};
    ////////////////////////////////////////////////////////////////////////////////
    // both ends joined by the interface, checker beside it
    uhcrm_if bus ();
    uhcrm_host uhcrm_host_inst (.ref_clk(ref_clk), .resetn(resetn), .swAddr(swAddr),
        .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .bus(bus));
    uhcrm_device #(.CHIP_ID(ID)) uhcrm_device_inst (.ref_clk(ref_clk), .resetn(resetn),
        .bus(bus), .hostCommand(hostCommand), .powerDownControl(powerDownControl),
        .lastRegion(lastRegion));
    uhcrm_sva uhcrm_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .addr(bus.addr),
        .wdata(bus.wdata), .rdata(bus.rdata), .wrStrobe(bus.wrStrobe),
        .rdStrobe(bus.rdStrobe), .rdValid(bus.rdValid));
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle write on the software port
    task automatic sw_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        swAddr <= a;
        swWdata <= v;
        swWr <= 1'h1;
        @(posedge ref_clk);
        swWr <= 1'h0;
    endtask : sw_wr
    // one-cycle read, data taken in the following cycle
    task automatic sw_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        swAddr <= a;
        swRd <= 1'h1;
        @(posedge ref_clk);
        swRd <= 1'h0;
        #1 v = swRdata;
    endtask : sw_rd
    // full device access through the host, busy polled with a bound
    task automatic reg_op(input logic [16:0] o, input logic [31:0] v, input logic w,
        output logic [31:0] r);
        logic [31:0] s;
        sw_wr(CMD_OFS, {15'h0, o});
        sw_wr(CMD_DATA, v);
        sw_wr(CMD_CTRL, {30'h0, w, 1'h1});
        s = 32'h1;
        for (int i = 0; i < 20 && s[0] !== 1'h0; i++) sw_rd(CMD_STAT, s);
        if (s[0] !== 1'h0) begin
            errors++;
            summarize();
        end
        sw_rd(CMD_DATA, r);
    endtask : reg_op
    // verdict and end of run
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////////
    // table pass, then mirrors and a second reset
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'h1;
        foreach (rows[i]) begin
            reg_op(rows[i].ofs, 32'h0, 1'h0, d);
            `CHK(d, rows[i].rst)
            reg_op(rows[i].ofs, rows[i].wd, 1'h1, d);
            reg_op(rows[i].ofs, 32'h0, 1'h0, d);
            `CHK(d, rows[i].aft)
            `CHK(lastRegion, rows[i].rgn)
        end
        `CHK(lastRegion, 2'h3)
        `CHK(hostCommand, 32'h00080B00)
        `CHK(powerDownControl, 32'h00000000)
        @(posedge ref_clk);
        resetn <= 1'h0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'h1;
        `CHK(powerDownControl, 32'h03E81BA0)
        `CHK(lastRegion, 2'h0)
        reg_op(17'h00134, 32'h0, 1'h0, d);
        `CHK(d, 32'hFFFFFFFF)
        summarize();
    end
endmodule : test_usb_host_capability_register_map
`default_nettype wire
